// [hw/wct_defs.svh]
// Constants of the wiper code target: bus address, presets and bit positions.
// Assumes it is included by bare name from the package and the design module.
// Notes on behaviour
// - Answer only bus address 0101110, held in the top seven address bits.
// - Direction bit 0 writes the wiper code, 1 reads it back.
// - A falling SDA while SCL is high starts a transfer; an address byte follows.
// - On an address match, pull SDA low through the ninth SCL pulse.
// - Every byte is eight bits, MSB first, plus acknowledge; written bytes are acknowledged.
// - In a written byte, drop the top bit and keep bits 6 to 0.
// - A read returns a zero bit followed by the seven-bit wiper code.
// - SDA changes only while SCL is low, except for start and stop.
// - A rising SDA while SCL is high stops the transfer; idle follows at the next rising SCL edge unless a start is pending.
// - Any number of written bytes follow one address; each updates the code.
// - Repeated reads return the current code and never change it.
// - The code selects exactly one of 128 taps, code D choosing tap D.
// - Serial input data is sampled on the rising SCL edge.
`ifndef WCT_DEFS_SVH
`define WCT_DEFS_SVH

// Own bus address, upper seven bits of the address byte.
`define WCT_BUS_ADDR     7'h2e
// Midscale preset of the wiper code.
`define WCT_RESET_CODE   7'h40
// Leading bit of every read data byte.
`define WCT_READ_LEAD    1'b0
// Direction bit value that selects a read.
`define WCT_DIR_READ     1'b1
// Bit counter value of the eighth bit of a byte.
`define WCT_LAST_BIT     3'h7
// Bit counter value right after the first address bit.
`define WCT_FIRST_BIT    3'h1
`define WCT_BIT_ZERO     3'h0
`define WCT_BIT_STEP     3'h1
// Level that an acknowledge puts on SDA.
`define WCT_ACK_LEVEL    1'b0

`endif

// [hw/wct_pkg.sv]
// Types shared by the wiper code target.
// Assumes the constants header is on the include path.
`include "wct_defs.svh"

package wct_pkg;

    // Link state; every code is a legal state.
    typedef enum logic [2:0] {
        WCT_IDLE     = 3'b000,
        WCT_ADDR     = 3'b001,
        WCT_ADDR_ACK = 3'b010,
        WCT_WR       = 3'b011,
        WCT_WR_ACK   = 3'b100,
        WCT_RD       = 3'b101,
        WCT_RD_ACK   = 3'b110,
        WCT_IGNORE   = 3'b111
    } wct_state_type;

    // New wiper code handed from the link domain to the core domain.
    typedef struct packed {
        logic       tog;
        logic [6:0] code;
    } wct_update_type;

endpackage

// [hw/wct_top.sv]
// Two-wire target that writes and reads back a seven-bit wiper code
// and decodes it onto one-hot tap selects.
// Assumes SCL is the link clock, free of glitches, and that SDA is an
// open-drain wire resolved outside from SDA_O and SDA_OE_O.
`timescale 1ns/1ps
`default_nettype none
`include "wct_defs.svh"

module wct_top
    import wct_pkg::*;
#(
    parameter int CODE_W = 7,
    parameter int TAPS   = 128
) (
    input  wire logic              CORE_CLK_I,
    input  wire logic              ARST_N_I,
    input  wire logic              SCL_I,
    input  wire logic              SDA_I,
    output logic                   SDA_O,
    output logic                   SDA_OE_O,
    output logic [CODE_W-1:0]      WIPER_CODE_O,
    output logic [TAPS-1:0]        TAP_SELECT_O
);

    ////////////////////////////////////////////////////////////////////////
    // Start and stop detection on SDA edges.

    logic                start_tog;
    logic                stop_tog;

    always_ff @(negedge SDA_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            start_tog <= 1'b0;
        end else if (SCL_I) begin
            start_tog <= ~start_tog;
        end
    end

    always_ff @(posedge SDA_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            stop_tog <= 1'b0;
        end else if (SCL_I) begin
            stop_tog <= ~stop_tog;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Link domain, rising SCL: sampling and the transfer state machine.
    // The start and stop toggles settle while SCL is high, long before the
    // next rising edge, so they are read here without a synchroniser.

    wct_state_type       state;
    logic [2:0]          bit_cnt;
    logic [7:0]          shift;
    logic                start_seen;
    logic                stop_seen;
    logic                start_pend;
    logic                stop_pend;
    logic [7:0]          addr_byte;
    wct_update_type      link_upd;

    assign start_pend = start_tog ^ start_seen;
    assign stop_pend  = stop_tog ^ stop_seen;
    assign addr_byte  = {shift[6:0], SDA_I};

    always_ff @(posedge SCL_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            start_seen <= 1'b0;
            stop_seen  <= 1'b0;
        end else begin
            start_seen <= start_tog;
            stop_seen  <= stop_tog;
        end
    end

    always_ff @(posedge SCL_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            state   <= WCT_IDLE;
            bit_cnt <= `WCT_BIT_ZERO;
            shift   <= 8'h00;
        end else if (start_pend) begin
            state   <= WCT_ADDR;
            bit_cnt <= `WCT_FIRST_BIT;
            shift   <= {7'h00, SDA_I};
        end else if (stop_pend) begin
            state   <= WCT_IDLE;
            bit_cnt <= `WCT_BIT_ZERO;
        end else begin
            unique case (state)
                WCT_IDLE: begin
                    bit_cnt <= `WCT_BIT_ZERO;
                end
                WCT_ADDR: begin
                    shift   <= addr_byte;
                    bit_cnt <= bit_cnt + `WCT_BIT_STEP;
                    if (bit_cnt == `WCT_LAST_BIT) begin
                        if (addr_byte[7:1] == `WCT_BUS_ADDR) begin
                            state <= WCT_ADDR_ACK;
                        end else begin
                            state <= WCT_IGNORE;
                        end
                    end
                end
                WCT_ADDR_ACK: begin
                    bit_cnt <= `WCT_BIT_ZERO;
                    if (shift[0] == `WCT_DIR_READ) begin
                        state <= WCT_RD;
                    end else begin
                        state <= WCT_WR;
                    end
                end
                WCT_WR: begin
                    shift   <= {shift[6:0], SDA_I};
                    bit_cnt <= bit_cnt + `WCT_BIT_STEP;
                    if (bit_cnt == `WCT_LAST_BIT) begin
                        state <= WCT_WR_ACK;
                    end
                end
                WCT_WR_ACK: begin
                    state   <= WCT_WR;
                    bit_cnt <= `WCT_BIT_ZERO;
                end
                WCT_RD: begin
                    bit_cnt <= bit_cnt + `WCT_BIT_STEP;
                    if (bit_cnt == `WCT_LAST_BIT) begin
                        state <= WCT_RD_ACK;
                    end
                end
                WCT_RD_ACK: begin
                    bit_cnt <= `WCT_BIT_ZERO;
                    if (SDA_I == `WCT_ACK_LEVEL) begin
                        state <= WCT_RD;
                    end else begin
                        state <= WCT_IGNORE;
                    end
                end
                WCT_IGNORE: begin
                    bit_cnt <= `WCT_BIT_ZERO;
                end
            endcase
        end
    end

    // The link copy of the code is what reads return; the core copy follows it.
    always_ff @(posedge SCL_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            link_upd.tog  <= 1'b0;
            link_upd.code <= `WCT_RESET_CODE;
        end else if (!start_pend && !stop_pend && state == WCT_WR_ACK) begin
            link_upd.tog  <= ~link_upd.tog;
            link_upd.code <= shift[CODE_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Link domain, falling SCL: driving SDA.

    logic [7:0]          read_byte;
    logic [2:0]          read_idx;

    assign read_byte = {`WCT_READ_LEAD, link_upd.code};
    assign read_idx  = `WCT_LAST_BIT - bit_cnt;

    always_ff @(negedge SCL_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            SDA_OE_O <= 1'b0;
        end else begin
            unique case (state)
                WCT_ADDR_ACK: begin
                    SDA_OE_O <= 1'b1;
                end
                WCT_WR_ACK: begin
                    SDA_OE_O <= 1'b1;
                end
                WCT_RD: begin
                    SDA_OE_O <= ~read_byte[read_idx];
                end
                WCT_RD_ACK: begin
                    // The controller owns the acknowledge slot of a read.
                    SDA_OE_O <= 1'b0;
                end
                WCT_IDLE: begin
                    SDA_OE_O <= 1'b0;
                end
                WCT_ADDR: begin
                    SDA_OE_O <= 1'b0;
                end
                WCT_WR: begin
                    SDA_OE_O <= 1'b0;
                end
                WCT_IGNORE: begin
                    SDA_OE_O <= 1'b0;
                end
            endcase
        end
    end

    // Open drain: the wire is only ever pulled low, so the level never moves.
    // It is still a register, so that every output leaves from a flip-flop.
    always_ff @(negedge SCL_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            SDA_O <= `WCT_ACK_LEVEL;
        end else begin
            SDA_O <= `WCT_ACK_LEVEL;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Core domain: toggle crossing, wiper code and tap decode.
    // The code word is stable for a whole byte after its toggle flips, far
    // longer than the three core edges that the toggle needs to cross.

    logic                upd_sync1;
    logic                upd_sync2;
    logic                upd_sync3;
    logic [CODE_W-1:0]   next_code;

    always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            upd_sync1 <= 1'b0;
            upd_sync2 <= 1'b0;
            upd_sync3 <= 1'b0;
        end else begin
            upd_sync1 <= link_upd.tog;
            upd_sync2 <= upd_sync1;
            upd_sync3 <= upd_sync2;
        end
    end

    always_comb begin
        next_code = WIPER_CODE_O;
        if (upd_sync2 != upd_sync3) begin
            next_code = link_upd.code;
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            WIPER_CODE_O <= `WCT_RESET_CODE;
        end else begin
            WIPER_CODE_O <= next_code;
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            TAP_SELECT_O <= {{(TAPS-1){1'b0}}, 1'b1} << `WCT_RESET_CODE;
        end else begin
            TAP_SELECT_O <= {{(TAPS-1){1'b0}}, 1'b1} << next_code;
        end
    end

endmodule

`default_nettype wire

// [bench/wct_checker.sv]
// Assertion checker for the wiper code target, bound to its top module.
// Assumes SCL and SDA are slow enough to be sampled as data by the core clock.
`timescale 1ns/1ps
`default_nettype none
module wct_checker
    import wct_pkg::*;
#(
    parameter int CODE_W = 7,
    parameter int TAPS   = 128
) (
    input wire logic              CORE_CLK_I,
    input wire logic              ARST_N_I,
    input wire logic              SCL_I,
    input wire logic              SDA_I,
    input wire logic              SDA_O,
    input wire logic              SDA_OE_O,
    input wire logic [CODE_W-1:0] WIPER_CODE_O,
    input wire logic [TAPS-1:0]   TAP_SELECT_O
);
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (!ARST_N_I);
    logic [3:0] hi_cnt;
    logic [4:0] oe_cnt;
    logic [3:0] chg_cnt;
    ////////////////////////////////////////////////////////////////
    // Run lengths of SCL high and of our pull, and the age of the code.
    always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            hi_cnt  <= 4'h0;
            oe_cnt  <= 5'h0;
            chg_cnt <= 4'hf;
        end else begin
            hi_cnt  <= !SCL_I ? 4'h0 : (hi_cnt == 4'hf ? hi_cnt : hi_cnt + 4'h1);
            oe_cnt  <= !SDA_OE_O ? 5'h0 : (oe_cnt == 5'h1f ? oe_cnt : oe_cnt + 5'h1);
            chg_cnt <= !$stable(WIPER_CODE_O) ? 4'h0
                     : (chg_cnt == 4'hf ? chg_cnt : chg_cnt + 4'h1);
        end
    end
    sequence start_seen;
        // SCL high over three samples: a data bit's high phase is too short for that.
        SCL_I && $past(SCL_I) && $past(SCL_I, 2) && $fell(SDA_I);
    endsequence
    sequence addr_quiet;
        !SDA_OE_O [*8];
    endsequence
    ////////////////////////////////////////////////////////////////
    chk_open_drain: assert property (SDA_O == 1'b0)
        else $error("data pin driven high");
    chk_tap_onehot: assert property (TAP_SELECT_O == (TAPS'(1) << WIPER_CODE_O))
        else $error("tap select does not match code");
    chk_reset_code: assert property ($rose(ARST_N_I) |-> WIPER_CODE_O == 7'h40)
        else $error("code not midscale after reset");
    chk_start_quiet: assert property (start_seen |-> addr_quiet)
        else $error("data pulled during address byte");
    chk_idle_release: assert property (hi_cnt > 4'd4 |-> !SDA_OE_O)
        else $error("data pulled while bus idle");
    chk_oe_bounded: assert property (oe_cnt < 5'd16)
        else $error("data pulled longer than one byte");
    chk_code_spacing: assert property (!$stable(WIPER_CODE_O) |-> chg_cnt >= 4'd10)
        else $error("code changed twice within one byte");
    chk_code_on_ack: assert property (
        !$stable(WIPER_CODE_O) |-> $past(SDA_OE_O, 2) || $past(SDA_OE_O, 3)
            || $past(SDA_OE_O, 4) || $past(SDA_OE_O, 5))
        else $error("code changed away from a write acknowledge");
endmodule
bind wct_top wct_checker #(.CODE_W(CODE_W), .TAPS(TAPS)) u_wct_chk (
    .CORE_CLK_I  (CORE_CLK_I),
    .ARST_N_I    (ARST_N_I),
    .SCL_I       (SCL_I),
    .SDA_I       (SDA_I),
    .SDA_O       (SDA_O),
    .SDA_OE_O    (SDA_OE_O),
    .WIPER_CODE_O(WIPER_CODE_O),
    .TAP_SELECT_O(TAP_SELECT_O)
);
`default_nettype wire

// [bench/wct_ctrl_model.sv]
// Behavioural two-wire controller driving SCL and pulling SDA low.
// Assumes the bench resolves the wire with a pull-up.
`timescale 1ns/1ps
`default_nettype none
module wct_ctrl_model (
    output logic     scl_o,
    output logic     sda_low_o,
    input wire logic sda_i
);
    // The clock stands still high between frames, as a real controller leaves it.
    initial begin
        scl_o     = 1'b1;
        sda_low_o = 1'b0;
    end
    task automatic put_bit(input logic b, output logic s);
        #40 sda_low_o = ~b;
        #40 scl_o = 1'b1;
        s = sda_i;
        #80 scl_o = 1'b0;
    endtask
    task automatic start();
        #200 sda_low_o = 1'b1;
        #200 scl_o = 1'b0;
    endtask
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            put_bit(tx[i], rx[i]);
        end
        put_bit(1'b1, ack);
    endtask
    task automatic stop();
        #40 sda_low_o = 1'b1;
        #40 scl_o = 1'b1;
        #200 sda_low_o = 1'b0;
        #200;
    endtask
endmodule
`default_nettype wire

// [bench/wct_top_tb.sv]
// Self-checking bench: a controller model writes and reads back the wiper code.
// Assumes the design top is wct_top with an open-drain, pulled-up data wire.
`timescale 1ns/1ps
`default_nettype none
module wct_top_tb;
    logic         clk = 1'b0;
    logic         rst_n;
    logic         scl;
    logic         sda_low;
    logic         sda_o;
    logic         sda_oe;
    logic [6:0]   code;
    logic [127:0] taps;
    logic [7:0]   exp_q[$];
    logic [7:0]   seen_val;
    logic [6:0]   cur = 7'h40;
    string        seen_name;
    event         got;
    int           fail_count = 0;
    int           n_checks = 0;
    wire logic    sda = ~(sda_low | (sda_oe & ~sda_o));
    initial begin
        forever #50 clk = ~clk;
    end
    wct_top #(.CODE_W(7), .TAPS(128)) DUT (.CORE_CLK_I(clk), .ARST_N_I(rst_n),
        .SCL_I(scl), .SDA_I(sda), .SDA_O(sda_o), .SDA_OE_O(sda_oe),
        .WIPER_CODE_O(code), .TAP_SELECT_O(taps));
    wct_ctrl_model u_ctl (.scl_o(scl), .sda_low_o(sda_low), .sda_i(sda));
    ////////////////////////////////////////////////////////////////
    task automatic note(input logic [7:0] v);
        exp_q.push_back(v);
    endtask
    task automatic see(input string nm, input logic [7:0] v);
        seen_name = nm;
        seen_val  = v;
        ->got;
        #1;
    endtask
    initial begin
        forever begin
            @(got);
            n_checks++;
            if (seen_val !== exp_q[0]) begin
                $display("unexpected %s: expected %h, seen %h", seen_name, exp_q[0], seen_val);
                fail_count++;
            end
            void'(exp_q.pop_front());
        end
    end
    task automatic check_code(input logic [6:0] c);
        note({1'b0, c});
        note(8'h01);
        see("wiper code", {1'b0, code});
        see("tap select", {7'h0, taps === (128'h1 << c)});
    endtask
    task automatic wr(input logic [23:0] d);
        logic [7:0] rx;
        logic       ack;
        u_ctl.start();
        note(8'h00);
        u_ctl.xfer({7'h2e, 1'b0}, rx, ack);
        see("write address ack", {7'h0, ack});
        for (int j = 0; j < 3; j++) begin
            note(8'h00);
            u_ctl.xfer(d[23-8*j -: 8], rx, ack);
            see("data ack", {7'h0, ack});
            cur = d[22-8*j -: 7];
            #600;
            check_code(cur);
        end
        u_ctl.stop();
    endtask
    task automatic rd(input logic [6:0] adr, input logic nak);
        logic [7:0] rx;
        logic       ack;
        u_ctl.start();
        note({7'h0, nak});
        u_ctl.xfer({adr, 1'b1}, rx, ack);
        see("read address ack", {7'h0, ack});
        note(nak ? 8'hff : {1'b0, cur});
        u_ctl.xfer(8'hff, rx, ack);
        see("read byte", rx);
        u_ctl.stop();
    endtask
    task automatic results();
        $display("checks %0d, mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        #3000000;
        fail_count++;
        results();
    end
    initial begin
        logic [7:0] r;
        r = 8'($urandom(32'h5f0d));
        // An edge on reset is needed: the link flops only reset on one.
        #1 rst_n = 1'b0;
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        check_code(7'h40);
        rd(7'h2e, 1'b0);
        for (int k = 0; k < 3; k++) begin
            r = 8'($urandom());
            wr({8'h80, 8'hff, r});
            rd(7'h2e, 1'b0);
        end
        rd(7'h2e, 1'b0);
        rd(7'h2f, 1'b1);
        check_code(cur);
        @(negedge clk);
        rst_n = 1'b0;
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        cur = 7'h40;
        check_code(7'h40);
        rd(7'h2e, 1'b0);
        results();
    end
endmodule
`default_nettype wire
